// File: core/frd_regs.sv
// frd_regs: rate select, data port, digital input and configuration control registers.
// assumes an AXI4-Lite master on sys_clk; drive pins synchronous to sys_clk.
`timescale 1ns/100ps
module frd_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic master_reset_in,
    input wire logic disk_changed_n,
    input wire frd_pkg::frd_status_wr_s status_wr,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output frd_pkg::frd_rate_s rate_out,
    output logic [7:0] digital_output,
    output logic core_soft_reset,
    output logic fifo_enabled,
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    output logic [3:0] precomp_steps,
    output logic [7:0] precomp_cycles
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic [3:0] aw_idx;
        logic [7:0] w_data;
        logic w_lane0;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        frd_pkg::frd_rate_s rate;
        logic [7:0] dor;
        logic no_precomp_flag;
        frd_pkg::frd_mode_e mode;
        logic [1:0] extra_rate_bits;
        logic soft_reset;
        logic fifo_enabled;
        logic cfg_pending;
        logic [1:0] stack_ptr;
        logic [7:0] cmd_byte;
        logic cmd_valid;
    } frd_state_s;

    frd_state_s st;
    frd_state_s next_st;
    logic [7:0] stack_rd_data;
    logic stack_clear;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte address to register index; low two bits ignored
    function automatic logic [3:0] word_idx(input logic [5:0] addr);
        word_idx = addr[5:2];
    endfunction

    function automatic logic read_mapped(input logic [3:0] idx);
        read_mapped = (idx == frd_pkg::IDX_MAIN_STATUS) || (idx == frd_pkg::IDX_DATA_FIFO_PORT)
            || (idx == frd_pkg::IDX_DIGITAL_INPUT_STATUS) || (idx == frd_pkg::IDX_MODE_CONTROL);
    endfunction

    function automatic logic write_mapped(input logic [3:0] idx);
        write_mapped = (idx == frd_pkg::IDX_DIGITAL_OUTPUT) || (idx == frd_pkg::IDX_RATE_SELECT)
            || (idx == frd_pkg::IDX_DATA_FIFO_PORT) || (idx == frd_pkg::IDX_CONFIGURATION_CONTROL)
            || (idx == frd_pkg::IDX_MODE_CONTROL);
    endfunction

    // reduced write current is high for 500k and 1M
    function automatic logic rwc_of(input logic [1:0] rate);
        rwc_of = (rate == frd_pkg::RATE_500K) || (rate == frd_pkg::RATE_1M);
    endfunction

    function automatic logic tape_of(input logic [1:0] rate, input logic [1:0] extra);
        tape_of = (rate == frd_pkg::RATE_300K) && (extra == frd_pkg::EXTRA_RATE_TAPE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // digital input read-back per mode
    function automatic logic [7:0] dig_in(input frd_state_s s, input logic chg_n);
        logic dens;
        dens = (s.rate.rate_field == frd_pkg::RATE_300K) || (s.rate.rate_field == frd_pkg::RATE_250K);
        unique case (s.mode)
            frd_pkg::FRD_MODE_ENHANCED:
                dig_in = {~chg_n, 4'hF, s.rate.rate_field, dens};
            frd_pkg::FRD_MODE_ALTERNATE:
                dig_in = {chg_n, 3'h7, s.dor[frd_pkg::DO_DMA_ENABLE_BIT], s.no_precomp_flag,
                          s.rate.rate_field};
            frd_pkg::FRD_MODE_AT, frd_pkg::FRD_MODE_SPARE:
                dig_in = {~chg_n, 7'h00};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic do_write;
        logic do_read;
        logic [3:0] ridx;
        logic [7:0] wd;
        do_write = 1'b0;
        do_read = 1'b0;
        ridx = word_idx(s_axi_araddr);
        wd = st.w_data;
        next_st = st;
        // pulses last one cycle
        next_st.soft_reset = 1'b0;
        next_st.cmd_valid = 1'b0;

        // write address and data are taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_idx = word_idx(s_axi_awaddr);
            next_st.awready = 1'b0;
        end

        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
            next_st.wready = 1'b0;
        end

        // both halves in: update and raise the answer in the same cycle
        if (!st.awready && !st.wready && !st.bvalid)
        begin
            do_write = 1'b1;
            next_st.bvalid = 1'b1;
            next_st.bresp = write_mapped(st.aw_idx) ? frd_pkg::RESP_OKAY : frd_pkg::RESP_SLVERR;
        end

        // answer taken: reopen both channels
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // lane 0 clear: no effect
        if (do_write && st.w_lane0)
        begin
            unique case (st.aw_idx)
                frd_pkg::IDX_DIGITAL_OUTPUT:
                    next_st.dor = wd;

                frd_pkg::IDX_RATE_SELECT:
                begin
                    next_st.soft_reset = wd[frd_pkg::RS_SOFT_RESET_BIT];
                    next_st.rate.power_down = wd[frd_pkg::RS_POWER_DOWN_BIT];
                    next_st.rate.precomp_field = wd[frd_pkg::RS_PRECOMP_LSB +: 3];
                    next_st.rate.rate_field = wd[frd_pkg::RS_RATE_LSB +: 2];
                end

                frd_pkg::IDX_DATA_FIFO_PORT:
                begin
                    next_st.cmd_byte = wd;
                    next_st.cmd_valid = 1'b1;
                    next_st.cfg_pending = (wd == frd_pkg::CONFIGURE_OPCODE);
                    if (st.cfg_pending)
                        next_st.fifo_enabled = 1'b1;
                end

                frd_pkg::IDX_CONFIGURATION_CONTROL:
                begin
                    next_st.rate.rate_field = wd[frd_pkg::RS_RATE_LSB +: 2];
                    if (st.mode == frd_pkg::FRD_MODE_ALTERNATE)
                        next_st.no_precomp_flag = wd[frd_pkg::CC_NO_PRECOMP_BIT];
                end

                frd_pkg::IDX_MODE_CONTROL:
                begin
                    next_st.mode = frd_pkg::frd_mode_e'(wd[frd_pkg::MODE_SEL_LSB +: 2]);
                    next_st.extra_rate_bits = wd[frd_pkg::MODE_EXTRA_RATE_LSB +: 2];
                end
                default:
                    next_st.cmd_valid = 1'b0;
            endcase
        end

        // read channel
        if (s_axi_arvalid && st.arready)
        begin
            do_read = 1'b1;
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = read_mapped(ridx) ? frd_pkg::RESP_OKAY : frd_pkg::RESP_SLVERR;
            next_st.rdata = '0;
        end

        if (do_read)
        begin
            unique case (ridx)
                frd_pkg::IDX_MAIN_STATUS:
                    // ready, FIFO state, power-down and configure pending; never the rate or precomp fields
                    next_st.rdata[7:0] = {1'b1, 4'h0, st.fifo_enabled, st.rate.power_down,
                                          st.cfg_pending};

                frd_pkg::IDX_DATA_FIFO_PORT:
                begin
                    next_st.rdata[7:0] = stack_rd_data;
                    next_st.stack_ptr = st.stack_ptr + 2'h1;
                end

                frd_pkg::IDX_DIGITAL_INPUT_STATUS:
                    next_st.rdata[7:0] = dig_in(st, disk_changed_n);
                frd_pkg::IDX_MODE_CONTROL:
                    next_st.rdata[7:0] = {4'h0, st.extra_rate_bits, st.mode};
                default:
                    next_st.rdata = '0;
            endcase
        end

        // answer taken: reopen reads
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // derived drive settings and resets
        next_st.rate.reduced_write_current = rwc_of(next_st.rate.rate_field);
        next_st.rate.tape_rate = tape_of(next_st.rate.rate_field, next_st.extra_rate_bits);

        // soft reset keeps the rate settings
        if (next_st.soft_reset)
        begin
            next_st.fifo_enabled = 1'b0;
            next_st.cfg_pending = 1'b0;
            next_st.stack_ptr = 2'h0;
        end

        // master reset wins over a write
        if (master_reset_in)
        begin
            next_st.dor = frd_pkg::DO_RESET;
            next_st.fifo_enabled = 1'b0;
            next_st.cfg_pending = 1'b0;
            next_st.stack_ptr = 2'h0;
        end
    end

    // stack empties on either reset
    assign stack_clear = st.soft_reset || master_reset_in;

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.rate.rate_field <= frd_pkg::RATE_RESET;
            st.rate.precomp_field <= frd_pkg::PRECOMP_RESET;
            st.rate.reduced_write_current <= 1'b1;
            st.dor <= frd_pkg::DO_RESET;
            st.mode <= frd_pkg::FRD_MODE_AT;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // submodules
    frd_status_stack u_stack (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(stack_clear),
        .wr(status_wr),
        .rd_idx(st.stack_ptr),
        .rd_data(stack_rd_data)
    );

    frd_precomp u_precomp (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .precomp_field(st.rate.precomp_field),
        .rate_field(st.rate.rate_field),
        .tape_rate(st.rate.tape_rate),
        .precomp_steps(precomp_steps),
        .precomp_cycles(precomp_cycles)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;

    assign rate_out = st.rate;
    assign digital_output = st.dor;
    assign core_soft_reset = st.soft_reset;
    assign fifo_enabled = st.fifo_enabled;
    assign cmd_byte = st.cmd_byte;
    assign cmd_valid = st.cmd_valid;

endmodule

// File: core/frd_pkg.sv
// frd_pkg: constants and carriers of the floppy rate and diagnostic register bank.
// assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package frd_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_DIGITAL_OUTPUT = 4'h2;
    localparam logic [3:0] IDX_RATE_SELECT = 4'h4;
    localparam logic [3:0] IDX_MAIN_STATUS = 4'h4;
    localparam logic [3:0] IDX_DATA_FIFO_PORT = 4'h5;
    localparam logic [3:0] IDX_DIGITAL_INPUT_STATUS = 4'h7;
    localparam logic [3:0] IDX_CONFIGURATION_CONTROL = 4'h7;
    localparam logic [3:0] IDX_MODE_CONTROL = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int RS_SOFT_RESET_BIT = 7;
    localparam int RS_POWER_DOWN_BIT = 6;
    localparam int RS_PRECOMP_LSB = 2;
    localparam int RS_RATE_LSB = 0;
    localparam int DO_DMA_ENABLE_BIT = 3;
    localparam int CC_NO_PRECOMP_BIT = 2;
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_EXTRA_RATE_LSB = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset values and codes
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [2:0] PRECOMP_RESET = 3'h0;
    localparam logic [7:0] DO_RESET = 8'h00;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [1:0] EXTRA_RATE_TAPE = 2'h2;
    localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
    localparam logic [2:0] PRECOMP_OFF = 3'h7;
    localparam logic [7:0] CONFIGURE_OPCODE = 8'h13;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // precompensation: one step is 20.83 ns, half of the 41.67 ns unit
    localparam int PRECOMP_STEP_PS = 20833;
    localparam int CLK_PERIOD_PS = 5000;
    localparam logic [3:0] STEPS_DEFAULT_NORMAL = 4'h6;
    localparam logic [3:0] STEPS_DEFAULT_1M = 4'h2;
    localparam logic [3:0] STEPS_DEFAULT_TAPE = 4'h1;
    localparam int PRECOMP_STEP_CYCLES = PRECOMP_STEP_PS / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        FRD_MODE_AT,
        FRD_MODE_ENHANCED,
        FRD_MODE_ALTERNATE,
        FRD_MODE_SPARE
    } frd_mode_e;

    // setting driven toward the drive interface
    typedef struct packed {
        logic [1:0] rate_field;
        logic tape_rate;
        logic reduced_write_current;
        logic power_down;
        logic [2:0] precomp_field;
    } frd_rate_s;

    // result written into the status stack by the controller core
    typedef struct packed {
        logic we;
        logic [1:0] idx;
        logic [7:0] data;
    } frd_status_wr_s;

endpackage

// File: core/frd_precomp.sv
// frd_precomp: turns the precompensation code and rate into a delay in steps and cycles.
// assumes synchronous inputs on sys_clk; outputs are registered.
`timescale 1ns/100ps
module frd_precomp (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [2:0] precomp_field,
    input wire logic [1:0] rate_field,
    input wire logic tape_rate,
    output logic [3:0] precomp_steps,
    output logic [7:0] precomp_cycles
);

    typedef struct packed {
        logic [3:0] steps;
        logic [7:0] cycles;
    } frd_pc_s;

    frd_pc_s st;
    frd_pc_s next_st;

    always_comb
    begin
        next_st = st;
        if (precomp_field == frd_pkg::PRECOMP_OFF)
            next_st.steps = 4'h0;
        else if (precomp_field == frd_pkg::PRECOMP_DEFAULT)
        begin
            if (tape_rate)
                next_st.steps = frd_pkg::STEPS_DEFAULT_TAPE;
            else if (rate_field == frd_pkg::RATE_1M)
                next_st.steps = frd_pkg::STEPS_DEFAULT_1M;
            else
                next_st.steps = frd_pkg::STEPS_DEFAULT_NORMAL;
        end
        else if (tape_rate)
            next_st.steps = {1'b0, precomp_field};
        else
            next_st.steps = {precomp_field, 1'b0};
        next_st.cycles = 8'(next_st.steps * frd_pkg::PRECOMP_STEP_CYCLES);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            st <= '0;
        else
            st <= next_st;
    end

    assign precomp_steps = st.steps;
    assign precomp_cycles = st.cycles;

endmodule

// File: core/frd_status_stack.sv
// frd_status_stack: four stacked status bytes, read data held in a register.
// assumes one writer (controller core) and a read index from the data port.
`timescale 1ns/100ps
module frd_status_stack (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire frd_pkg::frd_status_wr_s wr,
    input wire logic [1:0] rd_idx,
    output logic [7:0] rd_data
);

    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [7:0] rd;
    } frd_stk_s;

    frd_stk_s st;
    frd_stk_s next_st;

    always_comb
    begin
        next_st = st;
        if (clear)
            next_st.mem = '0;
        else if (wr.we)
            next_st.mem[wr.idx] = wr.data;
        next_st.rd = next_st.mem[rd_idx];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            st <= '0;
        else
            st <= next_st;
    end

    assign rd_data = st.rd;

endmodule

// File: dv/frd_drive_model.sv
// frd_drive_model: drive pins and controller core seen from the register bank.
// assumes sys_clk of the bench; fill loads four status bytes base+0..base+3.
`timescale 1ns/100ps
module frd_drive_model (
    input wire logic sys_clk,
    input wire logic disk_out,
    input wire logic fill,
    input wire logic [7:0] base,
    output logic disk_changed_n,
    output frd_pkg::frd_status_wr_s status_wr
);
    logic [2:0] cnt = 3'h0;
    logic [2:0] k;

    // pin is low while the disk is out
    assign disk_changed_n = !disk_out;
    assign k = 3'h4 - cnt;

    always @(posedge sys_clk)
    begin
        if (fill && cnt == 3'h0)
            cnt <= 3'h4;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
    end

    always_comb
    begin
        status_wr.we = cnt != 3'h0;
        status_wr.idx = k[1:0];
        status_wr.data = base + {6'h00, k[1:0]};
    end
endmodule

// File: dv/frd_regs_sva.sv
// frd_regs_sva: port assertions of the register bank.
// assumes it is bound into frd_regs.
`timescale 1ns/100ps
module frd_regs_sva (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic master_reset_in,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire frd_pkg::frd_rate_s rate_out,
    input wire logic [7:0] digital_output,
    input wire logic core_soft_reset,
    input wire logic fifo_enabled,
    input wire logic cmd_valid,
    input wire logic [3:0] precomp_steps
);
    logic [5:0] wa;
    logic [5:0] ra;
    logic [8:0] wd;
    logic bv_q;
    logic wok;

    // remember what each channel carried
    always_ff @(posedge sys_clk)
    begin
        bv_q <= s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready)
            wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wd <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
        if (s_axi_arvalid && s_axi_arready)
            ra <= s_axi_araddr;
    end
    // first cycle of an accepted lane-0 write response
    assign wok = s_axi_bvalid && !bv_q && wd[8] && s_axi_bresp == frd_pkg::RESP_OKAY;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_soft_reset;
        wok && wa == 6'h10 |-> core_soft_reset == wd[7];
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset differs from bit 7");
    property p_soft_only;
        core_soft_reset |-> wok && wa == 6'h10;
    endproperty
    a_soft_only: assert property (p_soft_only) else $error("stray soft reset pulse");
    property p_power_down;
        wok && wa == 6'h10 |-> rate_out.power_down == wd[6];
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down differs from bit 6");
    property p_rate_last;
        wok && (wa == 6'h10 || wa == 6'h1C) |-> rate_out.rate_field == wd[1:0];
    endproperty
    a_rate_last: assert property (p_rate_last) else $error("rate not from last write");
    property p_rwc;
        rate_out.reduced_write_current == (rate_out.rate_field inside {2'h0, 2'h3});
    endproperty
    a_rwc: assert property (p_rwc) else $error("reduced write current wrong");
    property p_tape;
        rate_out.tape_rate |-> rate_out.rate_field == 2'h1;
    endproperty
    a_tape: assert property (p_tape) else $error("tape rate with wrong rate field");
    property p_precomp_off;
        rate_out.precomp_field == 3'h7 [*3] |-> precomp_steps == 4'h0;
    endproperty
    a_precomp_off: assert property (p_precomp_off) else $error("precomp not disabled");
    property p_mr_clear;
        master_reset_in |=> digital_output == 8'h00 && !fifo_enabled;
    endproperty
    a_mr_clear: assert property (p_mr_clear) else $error("master reset left state");
    property p_fifo_on;
        $rose(fifo_enabled) |-> cmd_valid;
    endproperty
    a_fifo_on: assert property (p_fifo_on) else $error("fifo enabled without data write");
    property p_status_read;
        $rose(s_axi_rvalid) && ra == 6'h10 |-> s_axi_rdata[7:3] == 5'h10 && s_axi_rdata[2] == fifo_enabled;
    endproperty
    a_status_read: assert property (p_status_read) else $error("offset 0x10 read not status");
endmodule

bind frd_regs frd_regs_sva u_sva (.sys_clk, .rst_b, .master_reset_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .rate_out,
    .digital_output, .core_soft_reset, .fifo_enabled, .cmd_valid, .precomp_steps);

// File: dv/tb.sv
// tb: register bank bench over AXI4-Lite with a drive model.
// assumes frd_regs as top design module, 200 MHz clock.
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
        $display("FAIL %s expected %h seen %h", nm, exp, got); \
        err_count++; \
    end
module tb;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic master_reset_in = 1'h0;
    logic disk_out = 1'h0;
    logic fill = 1'h0;
    logic disk_changed_n;
    frd_pkg::frd_status_wr_s status_wr;
    logic [5:0] s_axi_awaddr = 6'h00;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'h0;
    logic [5:0] s_axi_araddr = 6'h00;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'h0;
    frd_pkg::frd_rate_s rate_out;
    logic [7:0] digital_output;
    logic core_soft_reset;
    logic fifo_enabled;
    logic [3:0] precomp_steps;
    logic [7:0] precomp_cycles;
    logic [7:0] cmd_byte;
    logic cmd_valid;
    logic [7:0] rd_data;
    logic [1:0] resp;
    logic [3:0] st;
    int err_count = 0;
    int total_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    frd_regs dut (.sys_clk, .rst_b, .master_reset_in, .disk_changed_n, .status_wr, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rate_out, .digital_output, .core_soft_reset, .fifo_enabled, .cmd_byte, .cmd_valid,
        .precomp_steps, .precomp_cycles);
    frd_drive_model u_drive (.sys_clk, .disk_out, .fill, .base(8'hA0), .disk_changed_n, .status_wr);

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1 && n < 40);
        s_axi_bready <= 1'h0;
        resp = s_axi_bresp;
        if (s_axi_bvalid !== 1'h1)
        begin
            err_count++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [5:0] a);
        int n;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1 && n < 40);
        s_axi_rready <= 1'h0;
        rd_data = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        if (s_axi_rvalid !== 1'h1)
        begin
            err_count++;
            finish_test();
        end
    endtask

    // digital input read-back per mode; dma enable is held at one
    function automatic logic [7:0] di_exp(input int m, input logic [1:0] r, input logic c_n, input logic np);
        case (m)
            1: return {~c_n, 4'hF, r, (r == 2'h1 || r == 2'h2)};
            2: return {c_n, 3'h7, 1'h1, np, r};
            default: return {~c_n, 7'h00};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'h1;
        `CHK("rate_out", 8'h10, rate_out)
        rd(6'h10);
        `CHK("main_status", 8'h80, rd_data)
        wr(6'h08, 8'h08);
        `CHK("digital_output", 8'h08, digital_output)
        for (int m = 0; m < 3; m++)
        begin
            wr(6'h20, 8'(m));
            for (int r = 0; r < 4; r++)
            begin
                disk_out <= r[0];
                wr(6'h1C, m == 2 ? {5'h00, r[1], 2'(r)} : {6'h00, 2'(r)});
                `CHK("rate_field", 2'(r), rate_out.rate_field)
                `CHK("rwc", (r == 0 || r == 3), rate_out.reduced_write_current)
                `CHK("tape", 1'h0, rate_out.tape_rate)
                rd(6'h1C);
                `CHK("digital_input", di_exp(m, 2'(r), !r[0], r[1]), rd_data)
            end
        end
        // extra rate bits 10 in at-compatible mode, then rates 00 and 01
        wr(6'h20, 8'h08);
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 8; c++)
            begin
                wr(6'h10, {3'h0, 3'(c), 1'h0, 1'(t)});
                repeat (3) @(posedge sys_clk);
                st = c == 7 ? 4'h0 : c == 0 ? (t == 1 ? 4'h1 : 4'h6) : 4'(c << (1 - t));
                `CHK("tape", 1'(t), rate_out.tape_rate)
                `CHK("steps", st, precomp_steps)
                `CHK("cycles", {2'h0, st, 2'h0}, precomp_cycles)
            end
        fill <= 1'h1;
        wr(6'h14, frd_pkg::CONFIGURE_OPCODE);
        fill <= 1'h0;
        `CHK("cmd_byte", frd_pkg::CONFIGURE_OPCODE, cmd_byte)
        `CHK("cmd_valid", 1'h1, cmd_valid)
        wr(6'h14, 8'h00);
        `CHK("fifo_enabled", 1'h1, fifo_enabled)
        rd(6'h10);
        `CHK("main_status", 8'h84, rd_data)
        for (int i = 0; i < 4; i++)
        begin
            rd(6'h14);
            `CHK("status_stack", 8'hA0 + 8'(i), rd_data)
        end
        wr(6'h10, 8'hC0);
        `CHK("soft_reset", 1'h1, core_soft_reset)
        `CHK("power_down", 1'h1, rate_out.power_down)
        rd(6'h10);
        `CHK("main_status", 8'h82, rd_data)
        wr(6'h10, 8'h00);
        `CHK("power_down", 1'h0, rate_out.power_down)
        master_reset_in <= 1'h1;
        @(posedge sys_clk);
        master_reset_in <= 1'h0;
        @(posedge sys_clk);
        `CHK("digital_output", 8'h00, digital_output)
        rd(6'h3C);
        `CHK("unmapped_resp", frd_pkg::RESP_SLVERR, resp)
        finish_test();
    end
endmodule
